// ===== rtl/afp_fault_protection.sv
// Fault supervisor for a stereo class-D amplifier output stage.
// Assumes asynchronous detector and pin inputs; audio clocks arrive as pins.
module afp_fault_protection #(
  parameter int unsigned SLOW_FALL_CYC = afp_pkg::SLOW_FALL_CYC,
  parameter int unsigned OT_RETRY_CYC  = afp_pkg::OT_RETRY_CYC,
  parameter int unsigned OC_RETRY_CYC  = afp_pkg::OC_RETRY_CYC,
  parameter int unsigned CLK_STOP_CYC  = afp_pkg::CLK_STOP_CYC
) (
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire afp_pkg::afp_det_t det_in,
  input  wire logic           analog_monitor_en,
  input  wire logic           mute_monitor_n,
  input  wire logic           mute_upper_trip,
  input  wire logic           mute_lower_trip,
  input  wire logic [2:0]     audio_clk,
  input  wire logic           sample_tick,
  input  wire logic [1:0]     ramp_step_sel,
  input  wire logic [1:0]     ramp_speed_sel,
  output logic                amp_fault_n,
  output logic                speaker_outputs_oe,
  output logic                output_shutdown,
  output logic                soft_mute,
  output logic                clock_fault_notice,
  output logic [7:0]          emergency_atten
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int unsigned NS = 14;
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  logic [NS-1:0] raw;

  assign raw = {det_in, analog_monitor_en, mute_monitor_n, mute_upper_trip,
                mute_lower_trip, audio_clk, sample_tick};

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Two flops per asynchronous input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  afp_pkg::afp_det_t s_det;
  logic       s_aen;
  logic       s_mute;
  logic       s_up;
  logic       s_lo;
  logic [2:0] s_clk;
  logic       s_tick;
  assign {s_det, s_aen, s_mute, s_up, s_lo, s_clk, s_tick} = sync_q;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [afp_pkg::CNT_W-1:0] ot_cnt;
    logic [afp_pkg::CNT_W-1:0] oc_cnt;
    logic [afp_pkg::CNT_W-1:0] fall_cnt;
    logic [2:0][12:0]          stop_cnt;
    logic [2:0]                clk_prev;
    logic                      ot_hold;
    logic                      oc_hold;
    logic                      dc_latch;
    logic                      mute_prev;
    logic                      falling;
    logic                      ext_mode;
    logic                      clk_err;
    logic                      tick_prev;
    logic [1:0]                spd_cnt;
    logic [7:0]                atten;
    afp_pkg::afp_mode_t        mode;
    logic                      fault_n;
    logic                      oe;
    logic                      shut;
    logic                      smute;
  } afp_state_t;

  afp_state_t s_q;
  afp_state_t s_d;

  logic [2:0] stalled;
  logic [2:0] clk_edge;
  logic [7:0] step_amt;
  logic       any_fault;
  logic       float_out;
  logic       supply_fail;
  logic       tick_rise;
  logic       ramp_now;

  // Per audio clock: detect edges and stall
  for (genvar i = 0; i < 3; i++) begin : g_clk
    assign clk_edge[i] = s_clk[i] ^ s_q.clk_prev[i];
    assign stalled[i]  = (s_q.stop_cnt[i] >= 13'(CLK_STOP_CYC)) && !s_clk[i];
  end

  // Step size in half-dB units: 4, 2, 1, 0.5 dB
  always_comb begin
    unique case (ramp_step_sel)
      2'h0: step_amt = 8'h08;
      2'h1: step_amt = 8'h04;
      2'h2: step_amt = 8'h02;
      2'h3: step_amt = 8'h01;
    endcase
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    s_d           = s_q;
    s_d.clk_prev  = s_clk;
    s_d.mute_prev = s_mute;
    s_d.tick_prev = s_tick;
    tick_rise     = s_tick && !s_q.tick_prev;

    // Clock stall counters
    for (int i = 0; i < 3; i++) begin
      if (clk_edge[i]) begin
        s_d.stop_cnt[i] = '0;
      end else if (s_q.stop_cnt[i] < 13'(CLK_STOP_CYC)) begin
        s_d.stop_cnt[i] = s_q.stop_cnt[i] + 13'h1;
      end
    end

    // Clock error set on stall, cleared on an edge of any clock once none is stalled
    if (|stalled) begin
      s_d.clk_err = 1'b1;
    end else if (s_q.clk_err && (&clk_edge | (clk_edge != 3'h0))) begin
      s_d.clk_err = 1'b0;
    end

    // Over-temperature: hold for retry time after event
    if (s_det.over_temperature_event) begin
      s_d.ot_hold = 1'b1;
      s_d.ot_cnt  = '0;
    end else if (s_q.ot_hold) begin
      if (s_q.ot_cnt >= afp_pkg::CNT_W'(OT_RETRY_CYC - 1)) begin
        s_d.ot_hold = 1'b0;
      end else begin
        s_d.ot_cnt = s_q.ot_cnt + 32'h1;
      end
    end

    // Over-current: hold for retry time after event
    if (s_det.over_current_event) begin
      s_d.oc_hold = 1'b1;
      s_d.oc_cnt  = '0;
    end else if (s_q.oc_hold) begin
      if (s_q.oc_cnt >= afp_pkg::CNT_W'(OC_RETRY_CYC - 1)) begin
        s_d.oc_hold = 1'b0;
      end else begin
        s_d.oc_cnt = s_q.oc_cnt + 32'h1;
      end
    end

    // DC offset latch; set wins over mute toggle or clock-error clear
    if (s_det.dc_offset_event) begin
      s_d.dc_latch = 1'b1;
    end else if ((s_mute != s_q.mute_prev) || s_q.clk_err) begin
      s_d.dc_latch = 1'b0;
    end

    // Fall timing of mute monitor pin
    if (s_mute && !s_q.mute_prev) begin
      s_d.falling  = 1'b0;
      s_d.ext_mode = 1'b0;
    end
    if (s_mute && s_up) begin
      s_d.falling  = 1'b1;
      s_d.fall_cnt = '0;
    end else if (s_q.falling && !s_mute) begin
      s_d.falling  = 1'b0;
      s_d.ext_mode = s_q.fall_cnt >= afp_pkg::CNT_W'(SLOW_FALL_CYC);
    end else if (s_q.falling && !s_up && s_q.fall_cnt != '1) begin
      s_d.fall_cnt = s_q.fall_cnt + 32'h1;
    end

    // External monitor mode sequencing
    s_d.mode = afp_pkg::AFP_NORMAL;
    if (s_q.ext_mode || s_d.ext_mode) begin
      if (!s_lo) begin
        s_d.mode = afp_pkg::AFP_SHUTDOWN;
      end else if (!s_up) begin
        s_d.mode = afp_pkg::AFP_SOFT_MUTE;
      end
    end

    // Emergency ramp-down on clock or supply failure
    supply_fail = s_det.supply_low_error || s_det.supply_high_error ||
                  (s_det.analog_supply_low && s_aen);
    ramp_now    = 1'b0;
    if (tick_rise) begin
      if (s_q.spd_cnt >= ramp_speed_sel) begin
        s_d.spd_cnt = '0;
        ramp_now    = 1'b1;
      end else begin
        s_d.spd_cnt = s_q.spd_cnt + 2'h1;
      end
    end
    if (s_q.clk_err || supply_fail) begin
      // Stopped clocks cannot tick, so a stall steps on the device clock
      if (ramp_now || s_q.clk_err) begin
        s_d.atten = (s_q.atten > afp_pkg::ATTEN_MAX - step_amt) ?
                    afp_pkg::ATTEN_MAX : s_q.atten + step_amt;
      end
    end else begin
      s_d.atten = '0;
    end

    // Outputs
    any_fault   = s_d.ot_hold || s_d.oc_hold || s_d.dc_latch;
    float_out   = any_fault || s_det.supply_low_error || s_det.supply_high_error ||
                  (s_det.analog_supply_low && s_aen) || s_d.clk_err;
    s_d.fault_n = !any_fault;
    s_d.oe      = !float_out && (s_d.mode != afp_pkg::AFP_SHUTDOWN);
    s_d.shut    = (s_d.mode == afp_pkg::AFP_SHUTDOWN);
    s_d.smute   = (s_d.mode != afp_pkg::AFP_NORMAL);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.mode    <= afp_pkg::AFP_NORMAL;
      s_q.fault_n <= 1'b1;
      s_q.mute_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Top outputs straight from flops
  assign amp_fault_n        = s_q.fault_n;
  assign speaker_outputs_oe = s_q.oe;
  assign output_shutdown    = s_q.shut;
  assign soft_mute          = s_q.smute;
  assign clock_fault_notice = s_q.clk_err;
  assign emergency_atten    = s_q.atten;

endmodule

// ===== common/afp_pkg.sv
// Package for the amplifier fault supervisor: timing constants, modes, detector flags.
// Assumes a 200 MHz device clock.
package afp_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SLOW_FALL_US     = 6000;                  // Least fall time for monitor mode
  localparam int unsigned SLOW_FALL_CYC    = SLOW_FALL_US * CLK_MHZ;
  localparam int unsigned OT_RETRY_US      = 1000;                  // Over-temperature retry time
  localparam int unsigned OT_RETRY_CYC     = OT_RETRY_US * CLK_MHZ;
  localparam int unsigned OC_RETRY_US      = 1000;                  // Over-current retry time
  localparam int unsigned OC_RETRY_CYC     = OC_RETRY_US * CLK_MHZ;
  localparam int unsigned CLK_STOP_CYC     = 4096;                  // Audio clock stalled after this
  localparam int unsigned CNT_W            = 32;

  // Volume ramp: attenuation in 0.5 dB units
  localparam logic [7:0]  ATTEN_MAX        = 8'hff;
  localparam logic [1:0]  STEP_RST         = 2'h0;                  // 4 dB step after reset
  localparam logic [1:0]  SPEED_RST        = 2'h0;                  // Every sample after reset

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    AFP_NORMAL,
    AFP_SOFT_MUTE,
    AFP_SHUTDOWN
  } afp_mode_t;

  typedef struct packed {
    logic over_temperature_event;
    logic over_current_event;
    logic dc_offset_event;
    logic supply_low_error;
    logic supply_high_error;
    logic analog_supply_low;
  } afp_det_t;

endpackage

// ===== tb/afp_fault_checker_assertions.sv
// Port checker for the amplifier fault supervisor.
// Assumes binding to afp_fault_protection on its single clock.
module afp_fault_checker #(
  parameter int unsigned CLK_STOP_CYC = 32
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire afp_pkg::afp_det_t det_in,
  input wire logic [2:0]        audio_clk,
  input wire logic              amp_fault_n,
  input wire logic              speaker_outputs_oe,
  input wire logic              output_shutdown,
  input wire logic              soft_mute,
  input wire logic              clock_fault_notice,
  input wire logic [7:0]        emergency_atten
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] stall_q;
  // ****
  // Cycles with every audio clock low
  // ****
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) stall_q <= 8'h00;
    else if (audio_clk != 3'h0) stall_q <= 8'h00;
    else if (stall_q != 8'hff) stall_q <= stall_q + 8'h01;
  end
  ot_fault_a: assert property ($rose(det_in.over_temperature_event) |-> ##[1:4] !amp_fault_n)
    else $error("fault low missing after over-temperature");
  ot_hold_a: assert property ($fell(det_in.over_temperature_event) |-> !amp_fault_n [*8])
    else $error("over-temperature fault released without retry wait");
  oc_fault_a: assert property ($rose(det_in.over_current_event) |-> ##[1:4] !speaker_outputs_oe)
    else $error("outputs driven after over-current");
  dc_latch_a: assert property ($fell(det_in.dc_offset_event) |-> !amp_fault_n [*6])
    else $error("offset fault not latched");
  supply_float_a: assert property ((det_in.supply_low_error || det_in.supply_high_error) [*4]
    |-> !speaker_outputs_oe)
    else $error("outputs driven during supply fault");
  clk_stop_a: assert property (stall_q == 8'(CLK_STOP_CYC + 8) |-> clock_fault_notice)
    else $error("stalled clocks not flagged");
  clk_hold_a: assert property ((clock_fault_notice && audio_clk == 3'h0) [*3] |-> !speaker_outputs_oe)
    else $error("outputs driven while clocks stopped");
  ramp_on_a: assert property ($rose(clock_fault_notice) |-> ##[1:6] emergency_atten != 8'h00)
    else $error("no emergency ramp on clock error");
  shut_mute_a: assert property (output_shutdown [*3] |-> soft_mute && !speaker_outputs_oe)
    else $error("shutdown without mute and float");
  cover property (!amp_fault_n ##1 amp_fault_n);
  cover property ($rose(clock_fault_notice));
  cover property ($rose(output_shutdown));
endmodule

bind afp_fault_protection afp_fault_checker #(.CLK_STOP_CYC(CLK_STOP_CYC)) u_chk (
  .clk(clk), .resetn(resetn), .det_in(det_in), .audio_clk(audio_clk), .amp_fault_n(amp_fault_n),
  .speaker_outputs_oe(speaker_outputs_oe), .output_shutdown(output_shutdown), .soft_mute(soft_mute),
  .clock_fault_notice(clock_fault_notice), .emergency_atten(emergency_atten));

// ===== tb/afp_ctrl_model.sv
// System controller model: runs audio clocks and pulses the mute pin.
// Assumes the device clock and bench commands.
module afp_ctrl_model (
  input wire logic   clk,
  input wire logic   resetn,
  input wire logic   amp_fault_n,
  input wire logic   clk_run,
  input wire logic   clr_req,
  input wire logic   hold_low,
  output logic       mute_monitor_n,
  output logic [2:0] audio_clk
);
  logic [3:0] div_q;
  logic [2:0] pulse_q;
  // ****
  // Clock divider and mute toggle pulse
  // ****
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q   <= 4'h0;
      pulse_q <= 3'h0;
    end else begin
      div_q <= div_q + 4'h1;
      if (clr_req && !amp_fault_n) pulse_q <= 3'h7;
      else if (pulse_q != 3'h0) pulse_q <= pulse_q - 3'h1;
    end
  end
  // Stopped clocks stay low as a clear request
  assign audio_clk = clk_run ? {div_q[3], div_q[1], div_q[0]} : 3'h0;
  assign mute_monitor_n = !(hold_low || pulse_q != 3'h0);
endmodule

// ===== tb/tb_amp_fault_protection.sv
// Self-checking bench for the amplifier fault supervisor.
// Assumes package, design, controller model and checker compiled first.
module tb_amp_fault_protection;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned RETRY = 50;
  logic clk, resetn, en, upper, lower, tick, run, clr, hold;
  logic fault_n, oe, shut, smute, notice, mute_n;
  logic [1:0] step, speed;
  logic [2:0] aclk;
  logic [7:0] atten;
  afp_pkg::afp_det_t det;
  int err_count, tests_run, cyc, k;
  afp_fault_protection #(.SLOW_FALL_CYC(200), .OT_RETRY_CYC(RETRY), .OC_RETRY_CYC(RETRY), .CLK_STOP_CYC(32)) dut (
    .clk(clk), .resetn(resetn), .det_in(det), .analog_monitor_en(en), .mute_monitor_n(mute_n),
    .mute_upper_trip(upper), .mute_lower_trip(lower), .audio_clk(aclk), .sample_tick(tick),
    .ramp_step_sel(step), .ramp_speed_sel(speed), .amp_fault_n(fault_n), .speaker_outputs_oe(oe),
    .output_shutdown(shut), .soft_mute(smute), .clock_fault_notice(notice), .emergency_atten(atten));
  afp_ctrl_model ctl (.clk(clk), .resetn(resetn), .amp_fault_n(fault_n), .clk_run(run), .clr_req(clr),
    .hold_low(hold), .mute_monitor_n(mute_n), .audio_clk(aclk));
  // ****
  // Clock, random sample strobe, watchdog
  // ****
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1 tick = ($urandom % 4) == 0;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hc2949350));
    {resetn, en, clr, hold, step, speed, tick} = '0;
    det = '0;
    {upper, lower, run} = 3'b111;
    wait_n(20);
    resetn = 1'b1;
    wait_n(8);
    chk("idle fault_n", 1, fault_n);
    chk("idle oe", 1, oe);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      det[5 - i] = 1'b1;
      wait_n(5 + $urandom % 20);
      chk("event fault_n", 0, fault_n);
      chk("event oe", 0, oe);
      det[5 - i] = 1'b0;
      wait_n(RETRY - 10);
      chk("retry fault_n", 0, fault_n);
      wait_n(20);
      chk("retried fault_n", 1, fault_n);
      chk("retried oe", 1, oe);
    end
    $display("test retry done");
    det.dc_offset_event = 1'b1;
    wait_n(5);
    det.dc_offset_event = 1'b0;
    wait_n(30);
    chk("dc latched", 0, fault_n);
    clr = 1'b1;
    wait_n(1);
    clr = 1'b0;
    wait_n(20);
    chk("dc cleared", 1, fault_n);
    chk("dc oe", 1, oe);
    $display("test offset done");
    det.dc_offset_event = 1'b1;
    wait_n(5);
    det.dc_offset_event = 1'b0;
    run = 1'b0;
    wait_n(80);
    chk("clock error", 1, notice);
    chk("clock oe", 0, oe);
    chk("ramp full", 8'hff, atten);
    run = 1'b1;
    wait_n(20);
    chk("clock back", 0, notice);
    chk("clock cleared dc", 1, fault_n);
    chk("clock resumed oe", 1, oe);
    chk("ramp off", 0, atten);
    $display("test clock done");
    repeat (6) begin
      k = $urandom % 2;
      det[2 - k] = 1'b1;
      wait_n(6);
      chk("supply oe", 0, oe);
      chk("supply fault_n", 1, fault_n);
      det[2 - k] = 1'b0;
      wait_n(6);
      chk("supply back oe", 1, oe);
    end
    $display("test supply done");
    det.analog_supply_low = 1'b1;
    wait_n(8);
    chk("monitor off", 1, oe & fault_n);
    en = 1'b1;
    wait_n(8);
    chk("monitor on", 0, oe & fault_n);
    det.analog_supply_low = 1'b0;
    en = 1'b0;
    wait_n(8);
    $display("test analog done");
    upper = 1'b0;
    wait_n(210);
    hold = 1'b1;
    wait_n(6);
    chk("soft mute", 1, smute);
    chk("no shutdown", 0, shut);
    lower = 1'b0;
    wait_n(6);
    chk("shutdown", 1, shut);
    chk("shutdown oe", 0, oe);
    {hold, upper, lower} = 3'b011;
    wait_n(10);
    upper = 1'b0;
    wait_n(2);
    hold = 1'b1;
    wait_n(6);
    lower = 1'b0;
    wait_n(6);
    chk("fast fall", 0, shut);
    {hold, upper, lower} = 3'b011;
    wait_n(10);
    $display("test monitor done");
    summarize();
  end
endmodule
